// File: design/pnps_regs.vh
// register offsets, field positions, reset values for next-page and status registers
`ifndef PNPS_REGS_VH
`define PNPS_REGS_VH
// register indexes (byte address is four times the index)
`define PNPS_IDX_NP_TX      8'h07
`define PNPS_IDX_DEV_STAT   8'h1C
`define PNPS_IDX_IRQ_STAT   8'h20
`define PNPS_IDX_IRQ_MASK   8'h21
`define PNPS_IDX_CTRL       8'h22
`define PNPS_IDX_LINK_CW    8'h23
// next-page transmit fields
`define PNPS_NP_NEXT        15
`define PNPS_NP_ACK         14
`define PNPS_NP_MSG         13
`define PNPS_NP_COMPLY      12
`define PNPS_NP_TOGGLE      11
`define PNPS_NP_CODE_MSB    10
`define PNPS_NP_RESET       16'h0000
`define PNPS_NP_WMASK       16'hB7FF
// device status fields
`define PNPS_ST_MISSING_SFD 8
`define PNPS_ST_CODE_VIOL   7
`define PNPS_ST_POL_FIXED   6
`define PNPS_ST_CABLE_DROP  5
`define PNPS_ST_UNLOCK      4
`define PNPS_ST_FALSE_CARR  3
`define PNPS_ST_JAM         2
`define PNPS_ST_FAST_LINK   1
`define PNPS_ST_SLOW_LINK   0
`define PNPS_ST_RESET       16'h0000
// control fields
`define PNPS_CTRL_POL_EN    0
`define PNPS_CTRL_RESET     8'h00
// base code word toggle position
`define PNPS_BASE_TOGGLE    11
// rxd error code for a manchester violation
`define PNPS_RXD_CODE_VIOL  4'h2
`endif

// File: design/pnps_latch.v
// latch-high flag bank: set wins over clear
`timescale 1ns/1ps
`default_nettype none
module pnps_latch #(
  parameter WIDTH = 6
) (
  input  wire             hclk,
  input  wire             hresetn,
  input  wire [WIDTH-1:0] set_in,
  input  wire [WIDTH-1:0] clear_in,
  output reg  [WIDTH-1:0] flags
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      // each flag sticks until cleared; a concurrent set keeps it high
      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          flags[i] <= 1'b0;
        else if (set_in[i])
          flags[i] <= 1'b1;
        else if (clear_in[i])
          flags[i] <= 1'b0;
      end
    end
  endgenerate
endmodule
`default_nettype wire

// File: design/pnps_toggle.v
// toggle bit tracker for next-page exchange
`timescale 1ns/1ps
`default_nettype none
module pnps_toggle (
  input  wire hclk,
  input  wire hresetn,
  input  wire base_exchanged,
  input  wire base_toggle,
  input  wire page_exchanged,
  output reg  toggle
);
  // first page takes inverse of base bit, then flips per exchanged page
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      toggle <= 1'b0;
    else if (base_exchanged)
      toggle <= ~base_toggle;
    else if (page_exchanged)
      toggle <= ~toggle;
  end
endmodule
`default_nettype wire

// File: design/pnps_top.v
// next-page transmit and device status registers behind an ahb-lite slave
// How it works
// - bit 15 next-page: software writes 0 for last page, 1 for more
// - bit 14 read-only, shows acknowledge from the exchanged link code word
// - bit 13 writable: 0 unformatted page, 1 formatted message page
// - bit 12 writable: 0 cannot comply, 1 will comply
// - bit 11 read-only, complement of previous exchanged toggle bit
// - first next page toggle is inverse of base word bit 11
// - bits 10..0 writable eleven-bit code field sent in next page
// - status bit 8 sets on frame missing start delimiter, 10 Mbit/s only
// - bits 8 and 7 latch high, clear on status read or reset
// - bit 7 sets on manchester violation, 10 Mbit/s only, error code goes on rxd
// - bit 6 reports corrected reversed polarity when enabled, 10 Mbit/s only, else 0
// - bit 5 latches disconnect until read, 100 Mbit/s only
// - bit 4 latches scrambler lock loss until read, 100 Mbit/s only
// - bit 3 latches false carrier until read, 100 Mbit/s only
// - bit 2 latches forced jam until read, 100 Mbit/s only
// - bit 1 reads 1 while fast link is up
// - bit 0 reads 1 while slow link is up
`timescale 1ns/1ps
`default_nettype none
`include "pnps_regs.vh"
module pnps_top (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        speed_100,
  input  wire        missing_sfd_evt,
  input  wire        code_viol_evt,
  input  wire        polarity_reversed,
  input  wire        cable_drop_evt,
  input  wire        scrambler_unlock_evt,
  input  wire        false_carrier_evt,
  input  wire        jam_forced_evt,
  input  wire        fast_link_up,
  input  wire        slow_link_up,
  input  wire        base_exchanged,
  input  wire        base_toggle,
  input  wire        page_exchanged,
  input  wire        partner_ack,
  output wire [15:0] tx_page,
  output wire        polarity_correct_enable,
  output reg  [3:0]  rxd_error_code,
  output reg         rxd_error_valid,
  output wire        irq
);
  // data phase state
  reg         dp_active;
  reg         dp_write;
  reg  [7:0]  dp_index;
  // register storage
  reg  [15:0] np_store;
  reg         ack_seen;
  reg  [8:0]  irq_stat;
  reg  [8:0]  irq_mask;
  reg  [7:0]  ctrl;
  wire        toggle;
  wire [5:0]  latch_flags;
  wire [5:0]  latch_set;
  wire [5:0]  latch_clear;
  wire [8:0]  evt_vec;
  wire [15:0] np_read;
  wire [15:0] status_read;
  wire        rd_status;
  reg  [31:0] next_hrdata;

  // word index of a byte address
  function [7:0] word_index;
    input [31:0] addr;
    begin
      word_index = addr[9:2];
    end
  endfunction

  // decide whether an index is mapped
  function is_mapped;
    input [7:0] idx;
    begin
      if (idx == `PNPS_IDX_NP_TX)
        is_mapped = 1'b1;
      else if (idx == `PNPS_IDX_DEV_STAT)
        is_mapped = 1'b1;
      else if (idx == `PNPS_IDX_IRQ_STAT)
        is_mapped = 1'b1;
      else if (idx == `PNPS_IDX_IRQ_MASK)
        is_mapped = 1'b1;
      else if (idx == `PNPS_IDX_CTRL)
        is_mapped = 1'b1;
      else
        is_mapped = 1'b0;
    end
  endfunction

  // zero-wait slave, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // capture address phase
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_active <= 1'b0;
      dp_write  <= 1'b0;
      dp_index  <= 8'h00;
    end
    else if (hready)
    begin
      dp_active <= hsel & htrans[1];
      dp_write  <= hwrite;
      dp_index  <= word_index(haddr);
    end
  end

  // status read happens in the address phase so the data is taken before clearing
  assign rd_status = hready & hsel & htrans[1] & ~hwrite &
                     (word_index(haddr) == `PNPS_IDX_DEV_STAT);

  // next-page register: writable fields only
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      np_store <= `PNPS_NP_RESET;
    else if (dp_active & dp_write & (dp_index == `PNPS_IDX_NP_TX))
      np_store <= hwdata[15:0] & `PNPS_NP_WMASK;
  end

  // acknowledge of the last exchanged code word
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ack_seen <= 1'b0;
    else if (page_exchanged | base_exchanged)
      ack_seen <= partner_ack;
  end

  pnps_toggle u_toggle (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .base_exchanged (base_exchanged),
    .base_toggle    (base_toggle),
    .page_exchanged (page_exchanged),
    .toggle         (toggle)
  );

  assign np_read = {np_store[`PNPS_NP_NEXT], ack_seen, np_store[`PNPS_NP_MSG],
                    np_store[`PNPS_NP_COMPLY], toggle, np_store[`PNPS_NP_CODE_MSB:0]};
  assign tx_page = np_read;

  // latch events qualified by speed mode; bit order: sfd, code, drop, unlock, carrier, jam
  assign latch_set = {missing_sfd_evt & ~speed_100,
                      code_viol_evt & ~speed_100,
                      cable_drop_evt & speed_100,
                      scrambler_unlock_evt & speed_100,
                      false_carrier_evt & speed_100,
                      jam_forced_evt & speed_100};
  assign latch_clear = {6{rd_status}};

  // an event still present during the clearing read keeps its flag set
  pnps_latch #(
    .WIDTH (6)
  ) u_latch (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .set_in   (latch_set),
    .clear_in (latch_clear),
    .flags    (latch_flags)
  );

  assign polarity_correct_enable = ctrl[`PNPS_CTRL_POL_EN];

  // assemble status word; unused upper bits read zero
  assign status_read = {7'h00,
                        latch_flags[5], latch_flags[4],
                        polarity_reversed & polarity_correct_enable & ~speed_100,
                        latch_flags[3], latch_flags[2], latch_flags[1], latch_flags[0],
                        fast_link_up,
                        slow_link_up};

  // manchester violation puts its error code on the receive data lines
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rxd_error_code  <= 4'h0;
      rxd_error_valid <= 1'b0;
    end
    else
    begin
      rxd_error_valid <= code_viol_evt & ~speed_100;
      rxd_error_code  <= (code_viol_evt & ~speed_100) ? `PNPS_RXD_CODE_VIOL : 4'h0;
    end
  end

  // interrupt events mirror status layout bits 8..0, levels of speed-qualified events
  assign evt_vec = {latch_set[5], latch_set[4], 1'b0, latch_set[3], latch_set[2],
                    latch_set[1], latch_set[0], 1'b0, 1'b0};

  // sticky interrupt status, write one to clear, set wins
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_stat <= 9'h000;
    else if (dp_active & dp_write & (dp_index == `PNPS_IDX_IRQ_STAT))
      irq_stat <= (irq_stat & ~hwdata[8:0]) | evt_vec;
    else
      irq_stat <= irq_stat | evt_vec;
  end

  // mask and control writes
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_mask <= 9'h000;
      ctrl     <= `PNPS_CTRL_RESET;
    end
    else if (dp_active & dp_write)
    begin
      if (dp_index == `PNPS_IDX_IRQ_MASK)
        irq_mask <= hwdata[8:0];
      else if (dp_index == `PNPS_IDX_CTRL)
        ctrl <= hwdata[7:0];
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // read mux in address phase, registered for data phase
  always @*
  begin
    next_hrdata = 32'h0000_0000;
    if (hready & hsel & htrans[1] & ~hwrite & is_mapped(word_index(haddr)))
    begin
      if (word_index(haddr) == `PNPS_IDX_NP_TX)
        next_hrdata = {16'h0000, np_read};
      else if (word_index(haddr) == `PNPS_IDX_DEV_STAT)
        next_hrdata = {16'h0000, status_read};
      else if (word_index(haddr) == `PNPS_IDX_IRQ_STAT)
        next_hrdata = {23'h000000, irq_stat};
      else if (word_index(haddr) == `PNPS_IDX_IRQ_MASK)
        next_hrdata = {23'h000000, irq_mask};
      else
        next_hrdata = {24'h000000, ctrl};
    end
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (hready)
      hrdata <= next_hrdata;
  end
endmodule
`default_nettype wire

// File: test/pnps_top_monitor.sv
// assertion checker on the ports of the register block
`timescale 1ns/1ps
`default_nettype none
module pnps_top_monitor (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        speed_100,
  input wire logic        code_viol_evt,
  input wire logic        fast_link_up,
  input wire logic        slow_link_up,
  input wire logic        base_exchanged,
  input wire logic        base_toggle,
  input wire logic        page_exchanged,
  input wire logic        partner_ack,
  input wire logic [15:0] tx_page,
  input wire logic [3:0]  rxd_error_code,
  input wire logic        rxd_error_valid
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // accepted status reads and next-page writes
  wire rd_st = hsel && htrans[1] && hready && !hwrite && haddr == 32'h70;
  wire wr_np = hsel && htrans[1] && hready && hwrite && haddr == 32'h1C;
  a_viol_code: assert property (code_viol_evt && !speed_100 |=> rxd_error_valid && rxd_error_code == 4'h2)
    else $error("rxd code missing");
  a_ack_capture: assert property (page_exchanged |=> tx_page[14] == $past(partner_ack))
    else $error("ack not captured");
  a_base_ack: assert property (base_exchanged |=> tx_page[14] == $past(partner_ack))
    else $error("base ack not captured");
  a_base_toggle: assert property (base_exchanged |=> tx_page[11] == !$past(base_toggle))
    else $error("first toggle wrong");
  a_page_flip: assert property (page_exchanged && !base_exchanged |=> tx_page[11] != $past(tx_page[11]))
    else $error("toggle did not flip");
  a_np_fields: assert property (wr_np |-> ##3 (tx_page & 16'hB7FF) == ($past(hwdata[15:0]) & 16'hB7FF))
    else $error("page fields not stored");
  a_stat_upper: assert property (rd_st |=> hrdata[31:9] == 23'h0)
    else $error("upper status bits set");
  a_fast_link: assert property (rd_st |=> hrdata[1] == $past(fast_link_up))
    else $error("fast link bit wrong");
  a_slow_link: assert property (rd_st |=> hrdata[0] == $past(slow_link_up))
    else $error("slow link bit wrong");
  a_pol_fast: assert property (rd_st && speed_100 |=> !hrdata[6])
    else $error("polarity bit at 100M");
endmodule
bind pnps_top pnps_top_monitor u_mon (.*);
`default_nettype wire

// File: test/pnps_partner.sv
// link partner model driving the page exchange strobes
`timescale 1ns/1ps
`default_nettype none
module pnps_partner (
  input  wire logic hclk,
  output var  logic base_exchanged,
  output var  logic page_exchanged,
  output wire logic base_toggle,
  output wire logic partner_ack
);
  logic [1:0] churn = 2'h0;
  logic       val_q = 1'b0;
  initial
  begin
    base_exchanged = 1'b0;
    page_exchanged = 1'b0;
  end
  // word bits only hold meaning during an exchange, else they wander
  always @(posedge hclk)
    churn <= churn + 2'h1;
  assign base_toggle = base_exchanged ? val_q : churn[0];
  assign partner_ack = (base_exchanged | page_exchanged) ? val_q : churn[1];
  // one exchange after gap idle cycles: base page or next page
  task automatic xchg(input logic is_base, input logic v, input int gap);
    repeat (gap) @(posedge hclk);
    val_q <= v;
    base_exchanged <= is_base;
    page_exchanged <= !is_base;
    @(posedge hclk);
    base_exchanged <= 1'b0;
    page_exchanged <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: test/pnps_top_test.sv
// self-checking bench for the next-page and status registers
`timescale 1ns/1ps
`default_nettype none
module pnps_top_test;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        speed_100 = 1'b0;
  logic        polarity_reversed = 1'b0;
  logic        fast_link_up = 1'b0;
  logic        slow_link_up = 1'b0;
  logic [5:0]  ev = 6'h0;
  wire         missing_sfd_evt, code_viol_evt, cable_drop_evt, scrambler_unlock_evt, false_carrier_evt, jam_forced_evt;
  wire         hreadyout, irq, base_exchanged, base_toggle, page_exchanged, partner_ack, hresp, pol_en;
  wire  [31:0] hrdata;
  wire  [15:0] tx_page;
  int          error_cnt = 0;
  int          samples_checked = 0;
  logic [31:0] rd;
  // rows: speed, event vector, expected status bits
  logic [15:0] rows [8] = '{16'h4100, 16'h2080, 16'h9020, 16'h8810, 16'h8408, 16'h8204, 16'hC000, 16'h0200};
  assign {missing_sfd_evt, code_viol_evt, cable_drop_evt, scrambler_unlock_evt, false_carrier_evt, jam_forced_evt} = ev;
  always #12.5 hclk = ~hclk;
  pnps_top uut (.*, .hsize(3'h2), .hready(hreadyout), .hresp(hresp), .polarity_correct_enable(pol_en),
    .rxd_error_code(), .rxd_error_valid());
  pnps_partner lp (.*);
  task automatic summarize;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait for hready
  task automatic wt;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1)
    begin
      error_cnt++;
      $display("mismatch at %0t: ready timeout", $time);
      summarize();
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    rd = hrdata;
  endtask
  task automatic rc(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic irq_is(input logic e);
    @(posedge hclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rc(32'h1C, 32'h0);
    rc(32'h70, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      speed_100 <= rows[i][15];
      @(posedge hclk);
      ev <= rows[i][14:9];
      @(posedge hclk);
      ev <= 6'h0;
      rc(32'h70, {23'h0, rows[i][8:0]});
      rc(32'h70, 32'h0);
    end
    ahb(1'b1, 32'h1C, 32'hFFFF);
    rc(32'h1C, 32'hB7FF);
    ahb(1'b1, 32'h1C, 32'h4800);
    rc(32'h1C, 32'h0);
    lp.xchg(1'b1, 1'b1, 1);
    rc(32'h1C, 32'h4000);
    lp.xchg(1'b1, 1'b0, 3);
    rc(32'h1C, 32'h0800);
    lp.xchg(1'b0, 1'b1, 1);
    rc(32'h1C, 32'h4000);
    lp.xchg(1'b0, 1'b0, 5);
    rc(32'h1C, 32'h0800);
    ahb(1'b1, 32'h88, 32'h1);
    @(posedge hclk);
    chk({31'h0, pol_en}, 32'h1);
    polarity_reversed <= 1'b1;
    fast_link_up <= 1'b1;
    rc(32'h70, 32'h42);
    speed_100 <= 1'b1;
    fast_link_up <= 1'b0;
    slow_link_up <= 1'b1;
    rc(32'h70, 32'h1);
    ahb(1'b1, 32'h88, 32'h0);
    speed_100 <= 1'b0;
    rc(32'h70, 32'h1);
    speed_100 <= 1'b1;
    slow_link_up <= 1'b0;
    ev <= 6'h01;
    rc(32'h70, 32'h4);
    rc(32'h70, 32'h4);
    ev <= 6'h0;
    rc(32'h70, 32'h4);
    rc(32'h70, 32'h0);
    rc(32'h40, 32'h0);
    // earlier scenarios left events pending: clear them all first
    ahb(1'b1, 32'h80, 32'h1FF);
    ahb(1'b1, 32'h84, 32'h1BC);
    irq_is(1'b0);
    ev <= 6'h08;
    @(posedge hclk);
    ev <= 6'h0;
    irq_is(1'b1);
    rc(32'h80, 32'h20);
    ahb(1'b1, 32'h84, 32'h0);
    irq_is(1'b0);
    ahb(1'b1, 32'h84, 32'h1BC);
    irq_is(1'b1);
    ahb(1'b1, 32'h80, 32'h20);
    irq_is(1'b0);
    // reset in mid-run returns every register to zero
    ahb(1'b1, 32'h1C, 32'h8001);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rc(32'h1C, 32'h0);
    rc(32'h80, 32'h0);
    chk({31'h0, pol_en}, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
